// ===== lcdhi_pkg.sv
// constants, types and reset values of the display host interface
package lcdhi_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int POR_HI_MS = 15;
	localparam int POR_LO_MS = 40;
	localparam int POR_HI_CYC = POR_HI_MS * (CLK_HZ / 1000);
	localparam int POR_LO_CYC = POR_LO_MS * (CLK_HZ / 1000);
	localparam int EXEC_NS = 39000;
	localparam int EXEC_CYC = (EXEC_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int INIT_W = 22;
	localparam int EXEC_W = 12;

	// ----------------------------------------
	// memory and codes
	// ----------------------------------------
	localparam int DM_DEPTH = 80;
	localparam logic [6:0] DM_LAST = 7'h4f;
	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [7:0] CMD_CLEAR = 8'h01;
	localparam logic [2:0] SYNC_PRE = 3'h4;
	localparam logic [3:0] FRAME_LAST = 4'hf;
	localparam logic [3:0] LOW_LAST = 4'h3;
	localparam logic [3:0] HIGH_FIRST = 4'h8;
	localparam logic [3:0] HIGH_LAST = 4'hb;
	localparam logic [1:0] SETTLE_LAST = 2'h3;

	// ----------------------------------------
	// configuration carried to the display core
	// ----------------------------------------
	typedef struct packed {
		logic host_width_select;
		logic two_line;
		logic ext_register_write_enable;
		logic graphic_blink_enable;
		logic low_power_select;
		logic display_on;
		logic cursor_on;
		logic char_blink;
		logic addr_increment;
		logic display_shift;
		logic font_width_select;
		logic inverted_cursor;
		logic four_line_select;
		logic [3:0] per_line_scroll_enable;
		logic [5:0] scroll_dot_amount;
	} lcdhi_cfg_t;

	localparam lcdhi_cfg_t CFG_RESET = '{
		host_width_select: 1'b1, two_line: 1'b1, ext_register_write_enable: 1'b0,
		graphic_blink_enable: 1'b0, low_power_select: 1'b0, display_on: 1'b0,
		cursor_on: 1'b0, char_blink: 1'b0, addr_increment: 1'b1, display_shift: 1'b0,
		font_width_select: 1'b0, inverted_cursor: 1'b0, four_line_select: 1'b0,
		per_line_scroll_enable: 4'h0, scroll_dot_amount: 6'h00};

	// ----------------------------------------
	// state encodings
	// ----------------------------------------
	typedef enum logic [1:0] {
		ST_INIT = 2'b10,
		ST_IDLE = 2'b00,
		ST_EXEC = 2'b01,
		ST_FILL = 2'b11
	} lcdhi_state_t;

	typedef enum logic [2:0] {
		SR_HUNT = 3'b000,
		SR_RW = 3'b001,
		SR_RS = 3'b011,
		SR_ZERO = 3'b010,
		SR_DATA = 3'b110
	} lcdhi_ser_t;

endpackage : lcdhi_pkg

// ===== lcdhi_host_if.sv
// host interface: reset init, parallel port, serial port, executor
`timescale 1ns/100ps

// What this block does
// - busy stays high through power-on init, 15 ms or 40 ms by supply.
// - init writes the space code into every display memory location.
// - init sets 8-bit width, two lines, extension writes, blink, low power off.
// - init turns display, cursor, blink off; entry increments, no shift.
// - init selects 5-dot font, normal cursor, no four-line, no scroll.
// - reset pin low reruns init, ignored during the power-on period.
// - 4-bit parallel uses upper four lines; a byte takes two nibbles.
// - 4-bit parallel sends the high nibble first, then the low nibble.
// - 4-bit busy and address read also takes two nibble transfers.
// - 8-bit parallel carries a whole byte in one transfer.
// - interface select low picks the serial port over the parallel bus.
// - serial is three-wire, clocked by the master's transfer clock.
// - serial clock works only with select low; select high clears the frame.
// - start byte is five ones, direction, register select, then zero.
// - a serial write byte is two bytes, low nibble first, zero padded.
// - a serial read returns each value in the same split-nibble form.
// - the sync pattern is watched during reads; master holds input low.
// - unchanged direction and select allow back-to-back items without start byte.
// - execution starts at the last bit; one arriving while busy is ignored.
// - busy stays high while an instruction executes, low when it ends.
module lcdhi_host_if #(
	parameter int POR_HI_CYCLES = lcdhi_pkg::POR_HI_CYC,
	parameter int POR_LO_CYCLES = lcdhi_pkg::POR_LO_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic low_voltage_strap,
	input wire logic ext_reset_n,
	input wire logic interface_select,
	input wire logic par_enable,
	input wire logic par_read,
	input wire logic register_select,
	input wire logic [7:0] parallel_data_lines_in,
	output logic [7:0] parallel_data_lines_out,
	output logic parallel_data_lines_oe,
	input wire logic sclk,
	input wire logic chip_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic busy_indication,
	output lcdhi_pkg::lcdhi_cfg_t cfg
);
	import lcdhi_pkg::*;

	// ----------------------------------------
	// pin synchronisers (clk domain)
	// ----------------------------------------
	logic [13:0] pin_s1;
	logic [13:0] pin_s2;
	logic en_d;
	logic strap_s;
	logic ext_rst_s;
	logic mode_par;
	logic en_s;
	logic rw_s;
	logic rs_s;
	logic [7:0] pd_s;

	// two flops per pin before any use
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1 <= 14'h0000;
			pin_s2 <= 14'h0000;
			en_d <= 1'b0;
		end else begin
			pin_s1 <= {low_voltage_strap, ext_reset_n, interface_select, par_enable,
				par_read, register_select, parallel_data_lines_in};
			pin_s2 <= pin_s1;
			en_d <= pin_s2[10];
		end
	end

	assign {strap_s, ext_rst_s, mode_par, en_s, rw_s, rs_s, pd_s} = pin_s2;

	// ----------------------------------------
	// serial receiver (sclk domain)
	// ----------------------------------------
	logic ser_clr;
	lcdhi_ser_t sst;
	lcdhi_ser_t next_sst;
	logic [2:0] ones;
	logic [2:0] next_ones;
	logic s_rw;
	logic next_s_rw;
	logic s_rs;
	logic next_s_rs;
	logic [3:0] bitn;
	logic [3:0] next_bitn;
	logic [3:0] nib;
	logic [3:0] next_nib;
	logic [3:0] low_nib;
	logic [3:0] next_low_nib;
	logic [7:0] tx_word;
	logic [7:0] next_tx_word;
	logic [15:0] rd_s1;
	logic [15:0] rd_s2;
	logic [15:0] rd_s3;
	logic [15:0] rd_src;
	logic [7:0] rd_pick;

	// select high or parallel mode holds the receiver cleared
	assign ser_clr = sys_rst | chip_select_n | mode_par;
	// status or data word, whichever the frame addresses
	assign rd_pick = s_rs ? rd_s3[7:0] : rd_s3[15:8];

	always_comb begin
		next_sst = sst;
		next_ones = serial_in ? ((ones == SYNC_PRE) ? ones : ones + 3'h1) : 3'h0;
		next_s_rw = s_rw;
		next_s_rs = s_rs;
		next_bitn = bitn;
		next_nib = nib;
		next_low_nib = low_nib;
		next_tx_word = tx_word;
		if (serial_in && ones == SYNC_PRE) begin
			next_sst = SR_RW;
			next_ones = 3'h0; // sync ones used up: a one in direction cannot resync
		end else begin
			case (sst)
				SR_RW: begin
					next_s_rw = serial_in;
					next_sst = SR_RS;
				end
				SR_RS: begin
					next_s_rs = serial_in;
					next_sst = SR_ZERO;
				end
				SR_ZERO: begin
					next_sst = serial_in ? SR_HUNT : SR_DATA;
					next_bitn = 4'h0;
					if (rd_s2 == rd_s3) begin
						next_tx_word = rd_pick;
					end
				end
				SR_DATA: begin
					next_bitn = bitn + 4'h1;
					if (bitn <= LOW_LAST || (bitn >= HIGH_FIRST && bitn <= HIGH_LAST)) begin
						next_nib[bitn[1:0]] = serial_in;
					end
					if (bitn == LOW_LAST) begin
						next_low_nib = next_nib;
					end
					if (bitn == FRAME_LAST && rd_s2 == rd_s3) begin
						next_tx_word = rd_pick;
					end
				end
				default: begin
					next_sst = SR_HUNT;
				end
			endcase
		end
	end

	// sample on the rising edge of the transfer clock
	always_ff @(posedge sclk or posedge ser_clr) begin
		if (ser_clr) begin
			sst <= SR_HUNT;
			ones <= 3'h0;
			s_rw <= 1'b0;
			s_rs <= 1'b0;
			bitn <= 4'h0;
			nib <= 4'h0;
			low_nib <= 4'h0;
			tx_word <= 8'h00;
			rd_s1 <= 16'h0000;
			rd_s2 <= 16'h0000;
			rd_s3 <= 16'h0000;
		end else begin
			sst <= next_sst;
			ones <= next_ones;
			s_rw <= next_s_rw;
			s_rs <= next_s_rs;
			bitn <= next_bitn;
			nib <= next_nib;
			low_nib <= next_low_nib;
			tx_word <= next_tx_word;
			rd_s1 <= rd_src;
			rd_s2 <= rd_s1;
			rd_s3 <= rd_s2;
		end
	end

	// ----------------------------------------
	// serial events toward clk (toggles)
	// ----------------------------------------
	logic frame_end;
	logic ser_wr_tg;
	logic ser_rd_tg;
	logic [8:0] ser_wr_word;
	logic [8:0] next_ser_wr_word;

	assign frame_end = (sst == SR_DATA) && (bitn == FRAME_LAST) && !(serial_in && ones == SYNC_PRE);

	always_comb begin
		next_ser_wr_word = ser_wr_word;
		if (frame_end && !s_rw) begin
			next_ser_wr_word = {s_rs, nib, low_nib};
		end
	end

	// toggles survive chip select so no false event appears
	always_ff @(posedge sclk or posedge sys_rst) begin
		if (sys_rst) begin
			ser_wr_tg <= 1'b0;
			ser_rd_tg <= 1'b0;
			ser_wr_word <= 9'h000;
		end else begin
			ser_wr_tg <= ser_wr_tg ^ (frame_end & ~s_rw & ~chip_select_n & ~mode_par);
			ser_rd_tg <= ser_rd_tg ^ (frame_end & s_rw & s_rs & ~chip_select_n & ~mode_par);
			ser_wr_word <= next_ser_wr_word;
		end
	end

	// ----------------------------------------
	// serial output on the falling edge
	// ----------------------------------------
	logic next_serial_out;

	always_comb begin
		next_serial_out = 1'b0;
		if (sst == SR_DATA && s_rw) begin
			if (bitn <= LOW_LAST) begin
				next_serial_out = tx_word[bitn[1:0]];
			end else if (bitn >= HIGH_FIRST && bitn <= HIGH_LAST) begin
				next_serial_out = tx_word[{1'b1, bitn[1:0]}];
			end
		end
	end

	always_ff @(negedge sclk or posedge ser_clr) begin
		if (ser_clr) begin
			serial_out <= 1'b0;
		end else begin
			serial_out <= next_serial_out;
		end
	end

	// ----------------------------------------
	// toggle synchronisers into clk
	// ----------------------------------------
	logic [2:0] wtg;
	logic [2:0] rtg;
	logic ser_wr_ev;
	logic ser_rd_ev;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			wtg <= 3'h0;
			rtg <= 3'h0;
		end else begin
			wtg <= {wtg[1:0], ser_wr_tg};
			rtg <= {rtg[1:0], ser_rd_tg};
		end
	end

	assign ser_wr_ev = wtg[2] ^ wtg[1];
	assign ser_rd_ev = rtg[2] ^ rtg[1];

	// ----------------------------------------
	// executor, init and parallel port (clk)
	// ----------------------------------------
	lcdhi_state_t st;
	lcdhi_state_t next_st;
	lcdhi_cfg_t next_cfg;
	logic [7:0] mem [DM_DEPTH];
	logic [6:0] ac;
	logic [6:0] next_ac;
	logic [6:0] fill_a;
	logic [6:0] next_fill_a;
	logic [INIT_W-1:0] init_cnt;
	logic [INIT_W-1:0] next_init_cnt;
	logic [EXEC_W-1:0] exec_cnt;
	logic [EXEC_W-1:0] next_exec_cnt;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic por_done;
	logic next_por_done;
	logic nib_ph;
	logic next_nib_ph;
	logic [3:0] hi_nib;
	logic [3:0] next_hi_nib;
	logic [7:0] next_pdo;
	logic [7:0] rd_word;
	logic [7:0] mem_rd;
	logic we;
	logic [6:0] wa;
	logic [7:0] wd;
	logic wr_ev;
	logic [7:0] wr_byte;
	logic wr_rs;
	logic rd_adv;
	logic p_take;

	assign mem_rd = (ac <= DM_LAST) ? mem[ac] : 8'h00;
	assign busy_indication = (st != ST_IDLE);
	assign rd_src = {busy_indication, ac, mem_rd};
	assign rd_word = rs_s ? mem_rd : {busy_indication, ac};
	assign p_take = mode_par && en_d && !en_s;
	assign parallel_data_lines_oe = mode_par && en_s && rw_s;

	// merge write and read-advance events of both ports
	always_comb begin
		wr_ev = 1'b0;
		wr_byte = pd_s;
		wr_rs = rs_s;
		rd_adv = 1'b0;
		next_nib_ph = nib_ph;
		next_hi_nib = hi_nib;
		if (!mode_par) begin
			wr_ev = ser_wr_ev;
			wr_byte = ser_wr_word[7:0];
			wr_rs = ser_wr_word[8];
			rd_adv = ser_rd_ev;
		end else if (p_take) begin
			if (!cfg.host_width_select) begin
				next_nib_ph = ~nib_ph;
				if (!nib_ph) begin
					next_hi_nib = pd_s[7:4];
				end else begin
					wr_ev = !rw_s;
					wr_byte = {hi_nib, pd_s[7:4]};
					rd_adv = rw_s && rs_s;
				end
			end else begin
				wr_ev = !rw_s;
				rd_adv = rw_s && rs_s;
			end
		end
	end

	// parallel read data, high nibble first in 4-bit mode
	always_comb begin
		if (cfg.host_width_select) begin
			next_pdo = rd_word;
		end else if (!nib_ph) begin
			next_pdo = {rd_word[7:4], 4'h0};
		end else begin
			next_pdo = {rd_word[3:0], 4'h0};
		end
	end

	// main sequencer: init, fill, execute
	always_comb begin
		next_st = st;
		next_cfg = cfg;
		next_ac = ac;
		next_fill_a = fill_a;
		next_init_cnt = init_cnt;
		next_exec_cnt = exec_cnt;
		next_settle = settle;
		next_por_done = por_done;
		we = 1'b0;
		wa = ac;
		wd = wr_byte;
		case (st)
			ST_INIT: begin
				next_cfg = CFG_RESET;
				next_ac = 7'h00;
				if (fill_a <= DM_LAST) begin
					we = 1'b1;
					wa = fill_a;
					wd = SPACE_CODE;
					next_fill_a = fill_a + 7'h01;
				end
				if (settle != SETTLE_LAST) begin
					next_settle = settle + 2'h1;
					if (settle == SETTLE_LAST - 2'h1) begin
						next_init_cnt = strap_s ? POR_LO_CYCLES[INIT_W-1:0] : POR_HI_CYCLES[INIT_W-1:0];
					end
				end else if (init_cnt <= 1) begin
					// hold busy until the memory fill has also finished
					if (fill_a > DM_LAST) begin
						next_st = ST_IDLE;
						next_por_done = 1'b1;
					end
				end else begin
					next_init_cnt = init_cnt - 1'b1;
				end
			end
			ST_FILL: begin
				we = 1'b1;
				wa = fill_a;
				wd = SPACE_CODE;
				next_fill_a = fill_a + 7'h01;
				if (fill_a == DM_LAST) begin
					next_st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_exec_cnt = exec_cnt - 1'b1;
				if (exec_cnt <= 1) begin
					next_st = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (rd_adv) begin
					next_ac = cfg.addr_increment ? ac + 7'h01 : ac - 7'h01;
				end
				if (wr_ev) begin
					next_st = ST_EXEC;
					next_exec_cnt = EXEC_CYC[EXEC_W-1:0];
					if (wr_rs) begin
						we = (ac <= DM_LAST);
						next_ac = cfg.addr_increment ? ac + 7'h01 : ac - 7'h01;
					end else if (wr_byte[7]) begin
						next_ac = wr_byte[6:0];
					end else if (wr_byte[7:5] == 3'h1) begin
						next_cfg.host_width_select = wr_byte[4];
						next_cfg.two_line = wr_byte[3];
						next_cfg.ext_register_write_enable = wr_byte[2];
						if (wr_byte[2]) begin
							next_cfg.graphic_blink_enable = wr_byte[1];
							next_cfg.low_power_select = wr_byte[0];
						end
					end else if (wr_byte[7:3] == 5'h01) begin
						if (cfg.ext_register_write_enable) begin
							next_cfg.font_width_select = wr_byte[2];
							next_cfg.inverted_cursor = wr_byte[1];
							next_cfg.four_line_select = wr_byte[0];
						end else begin
							next_cfg.display_on = wr_byte[2];
							next_cfg.cursor_on = wr_byte[1];
							next_cfg.char_blink = wr_byte[0];
						end
					end else if (wr_byte[7:2] == 6'h01) begin
						next_cfg.addr_increment = wr_byte[1];
						next_cfg.display_shift = wr_byte[0];
					end else if (wr_byte == CMD_CLEAR) begin
						next_st = ST_FILL;
						next_fill_a = 7'h00;
						next_ac = 7'h00;
						next_cfg.addr_increment = 1'b1;
					end else if (wr_byte[7:1] == 7'h01) begin
						next_ac = 7'h00;
					end
				end
			end
			default: begin
				next_st = ST_INIT;
			end
		endcase
		if (!ext_rst_s && por_done) begin
			next_st = ST_INIT;
			next_settle = 2'h0;
			next_fill_a = 7'h00;
		end
	end

	// register the sequencer state
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= ST_INIT;
			cfg <= CFG_RESET;
			ac <= 7'h00;
			fill_a <= 7'h00;
			init_cnt <= '0;
			exec_cnt <= '0;
			settle <= 2'h0;
			por_done <= 1'b0;
			nib_ph <= 1'b0;
			hi_nib <= 4'h0;
			parallel_data_lines_out <= 8'h00;
		end else begin
			st <= next_st;
			cfg <= next_cfg;
			ac <= next_ac;
			fill_a <= next_fill_a;
			init_cnt <= next_init_cnt;
			exec_cnt <= next_exec_cnt;
			settle <= next_settle;
			por_done <= next_por_done;
			nib_ph <= (st == ST_INIT) ? 1'b0 : next_nib_ph;
			hi_nib <= next_hi_nib;
			parallel_data_lines_out <= next_pdo;
		end
	end

	// display memory write port
	always_ff @(posedge clk) begin
		if (we && wa <= DM_LAST) begin
			mem[wa] <= wd;
		end
	end

endmodule : lcdhi_host_if

// ===== lcdhi_host_if_properties.sv
// concurrent checks on the display host interface ports
`timescale 1ns/100ps
module lcdhi_host_if_properties #(
	parameter int POR_HI_CYCLES = lcdhi_pkg::POR_HI_CYC,
	parameter int POR_LO_CYCLES = lcdhi_pkg::POR_LO_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ext_reset_n,
	input wire logic interface_select,
	input wire logic par_enable,
	input wire logic par_read,
	input wire logic [7:0] parallel_data_lines_out,
	input wire logic parallel_data_lines_oe,
	input wire logic chip_select_n,
	input wire logic serial_out,
	input wire logic busy_indication,
	input wire lcdhi_pkg::lcdhi_cfg_t cfg
);
	import lcdhi_pkg::*;
	localparam int BUSY_MAX = EXEC_CYC + POR_LO_CYCLES + DM_DEPTH + 64;
	int busy_run;
	int next_busy_run;

	// length of the current busy stretch
	always_comb begin
		next_busy_run = busy_indication ? busy_run + 1 : 0;
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_run <= 0;
		end else begin
			busy_run <= next_busy_run;
		end
	end

	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	AST_RST_BUSY: assert property (
		$fell(sys_rst) |-> busy_indication [*8]) else $error("busy dropped right after reset");
	AST_BUSY_MIN: assert property (
		$fell(busy_indication) |-> busy_run >= POR_HI_CYCLES) else $error("busy stretch too short");
	AST_BUSY_MAX: assert property (
		busy_run <= BUSY_MAX) else $error("busy never clears");
	AST_EXEC_HOLD: assert property (
		$rose(busy_indication) |-> busy_indication [*8]) else $error("busy pulse too short");
	AST_RST_CFG: assert property (
		$fell(sys_rst) |-> cfg == CFG_RESET) else $error("settings wrong after reset");
	AST_WR_BUSY: assert property (
		$fell(par_enable) && !par_read && interface_select && cfg.host_width_select && !busy_indication
		|-> ##[1:8] busy_indication) else $error("write did not start execution");
	AST_CFG_HOLD: assert property (
		(busy_indication && ext_reset_n) [*6] |-> $stable(cfg)) else $error("settings changed while busy");
	AST_SER_IDLE: assert property (
		chip_select_n [*2] |-> !serial_out) else $error("serial output active while deselected");
	AST_OE_SER: assert property (
		(!interface_select) [*4] |-> !parallel_data_lines_oe) else $error("parallel bus driven in serial mode");
	AST_OE_RD: assert property (
		(!par_read) [*4] |-> !parallel_data_lines_oe) else $error("parallel bus driven on write");
	AST_NIB_LOW: assert property (
		(parallel_data_lines_oe && !cfg.host_width_select) [*2] |-> parallel_data_lines_out[3:0] == 4'h0)
		else $error("low lines active in nibble mode");
endmodule : lcdhi_host_if_properties

bind lcdhi_host_if lcdhi_host_if_properties #(
	.POR_HI_CYCLES(POR_HI_CYCLES),
	.POR_LO_CYCLES(POR_LO_CYCLES)
) u_props (
	.clk(clk), .sys_rst(sys_rst), .ext_reset_n(ext_reset_n), .interface_select(interface_select),
	.par_enable(par_enable), .par_read(par_read), .parallel_data_lines_out(parallel_data_lines_out),
	.parallel_data_lines_oe(parallel_data_lines_oe), .chip_select_n(chip_select_n),
	.serial_out(serial_out), .busy_indication(busy_indication), .cfg(cfg)
);

// ===== lcdhi_ser_master.sv
// serial master model on the three-wire link
`timescale 1ns/100ps
module lcdhi_ser_master (
	output logic sclk,
	output logic chip_select_n,
	output logic serial_in,
	input wire logic serial_out
);
	localparam int HALF = 6;

	// link idle: clock still, device deselected
	initial begin
		sclk = 1'b0;
		chip_select_n = 1'b1;
		serial_in = 1'b1;
	end

	// one bit: data set with clock low, reply taken at the rise
	task automatic bit_xfer(input logic tx, output logic rx);
		serial_in = tx;
		#HALF;
		sclk = 1'b1;
		rx = serial_out;
		#HALF;
		sclk = 1'b0;
	endtask : bit_xfer

	// selects the device, sends sync ones, direction, select, zero
	task automatic start(input logic rw, input logic rs);
		logic d;
		chip_select_n = 1'b0;
		for (int i = 0; i < 8; i++) begin
			bit_xfer(i < 5 ? 1'b1 : i == 5 ? rw : i == 6 ? rs : 1'b0, d);
		end
	endtask : start

	// one item as two bytes, low nibble first, each nibble zero padded
	task automatic word(input logic [7:0] tx, output logic [7:0] rx);
		logic d;
		for (int i = 0; i < 16; i++) begin
			bit_xfer(i[2] ? 1'b0 : tx[{i[3], i[1:0]}], d);
			if (!i[2]) rx[{i[3], i[1:0]}] = d;
		end
	endtask : word

	// deselect; data line no longer keeps its last level
	task automatic stop();
		chip_select_n = 1'b1;
		serial_in = ~serial_in;
		#(2 * HALF); // deselect lasts before the next select
	endtask : stop
endmodule : lcdhi_ser_master

// ===== tb.sv
// self-checking testbench for the display host interface
`timescale 1ns/100ps
module tb;
	import lcdhi_pkg::*;
	localparam int POR_HI = 100;
	localparam int POR_LO = 200;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic low_voltage_strap = 1'b0;
	logic ext_reset_n = 1'b1;
	logic interface_select = 1'b1;
	logic par_enable = 1'b0;
	logic par_read = 1'b0;
	logic register_select = 1'b0;
	logic [7:0] pd_in = 8'h00;
	logic [7:0] pd_out;
	logic pd_oe;
	logic sclk;
	logic chip_select_n;
	logic serial_in;
	logic serial_out;
	logic busy_indication;
	lcdhi_cfg_t cfg;
	lcdhi_cfg_t exp_cfg;
	int bad_count = 0;
	int total_checks = 0;
	int n;
	logic [7:0] rd;
	logic [7:0] v;
	logic d;

	always #10 clk = ~clk;

	lcdhi_host_if #(.POR_HI_CYCLES(POR_HI), .POR_LO_CYCLES(POR_LO)) dut (
		.clk(clk), .sys_rst(sys_rst), .low_voltage_strap(low_voltage_strap), .ext_reset_n(ext_reset_n),
		.interface_select(interface_select), .par_enable(par_enable), .par_read(par_read),
		.register_select(register_select), .parallel_data_lines_in(pd_in), .parallel_data_lines_out(pd_out),
		.parallel_data_lines_oe(pd_oe), .sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out), .busy_indication(busy_indication), .cfg(cfg));

	lcdhi_ser_master pm (.sclk(sclk), .chip_select_n(chip_select_n), .serial_in(serial_in),
		.serial_out(serial_out));

	// compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : summarize

	// bounded wait for busy low, reports cycles spent
	task automatic wait_idle(output int cyc);
		cyc = 0;
		while (busy_indication !== 1'b0) begin
			@(negedge clk);
			cyc++;
			if (cyc > 3000) begin
				chk("busy wait", 32'h0, 32'h1);
				summarize();
			end
		end
	endtask : wait_idle

	task automatic idle();
		int c;
		repeat (8) @(negedge clk);
		wait_idle(c);
	endtask : idle

	// one parallel strobe; read data taken while strobe is high
	task automatic par(input logic rdn, input logic rs, input logic [7:0] dat, output logic [7:0] q);
		@(negedge clk);
		par_read = rdn;
		register_select = rs;
		pd_in = dat;
		par_enable = 1'b1;
		repeat (5) @(negedge clk);
		q = pd_out;
		if (rdn) chk("bus enable", 32'(pd_oe), 32'h1);
		par_enable = 1'b0;
		repeat (4) @(negedge clk);
	endtask : par

	// expected settings after an instruction
	function automatic lcdhi_cfg_t apply(input lcdhi_cfg_t c, input logic [7:0] cmd);
		if (cmd[7:3] == 5'h01) begin
			if (c.ext_register_write_enable) begin
				{c.font_width_select, c.inverted_cursor, c.four_line_select} = cmd[2:0];
			end else begin
				{c.display_on, c.cursor_on, c.char_blink} = cmd[2:0];
			end
		end else if (cmd[7:2] == 6'h01) begin
			{c.addr_increment, c.display_shift} = cmd[1:0];
		end else if (cmd[7:5] == 3'h1) begin
			{c.host_width_select, c.two_line, c.ext_register_write_enable} = cmd[4:2];
			if (cmd[2]) begin
				{c.graphic_blink_enable, c.low_power_select} = cmd[1:0];
			end
		end
		return c;
	endfunction : apply

	// main sequence
	initial begin
		void'($urandom(16));
		repeat (4) @(posedge clk);
		@(negedge clk);
		sys_rst = 1'b0;
		chk("busy at init", 32'(busy_indication), 32'h1);
		wait_idle(n);
		chk("short init", 32'(n >= POR_HI && n < POR_LO), 32'h1);
		chk("reset cfg", 32'(cfg), 32'(CFG_RESET));
		exp_cfg = CFG_RESET;
		for (int i = 0; i < 6; i++) begin
			v = i[0] ? {6'h01, 2'($urandom())} : {5'h01, 3'($urandom())};
			par(1'b0, 1'b0, v, rd);
			exp_cfg = apply(exp_cfg, v);
			par(1'b0, 1'b0, v ^ 8'h03, rd);
			par(1'b1, 1'b0, 8'h00, rd);
			chk("busy read", 32'(rd[7]), 32'h1);
			wait_idle(n);
			chk("cfg 8-bit", 32'(cfg), 32'(exp_cfg));
		end
		// extension writes enabled, then extension settings
		for (int i = 0; i < 2; i++) begin
			v = i ? {5'h01, 3'($urandom())} : {6'h0f, 2'($urandom())};
			par(1'b0, 1'b0, v, rd);
			exp_cfg = apply(exp_cfg, v);
			wait_idle(n);
		end
		chk("cfg extension", 32'(cfg), 32'(exp_cfg));
		par(1'b0, 1'b0, 8'h28, rd);
		exp_cfg = apply(exp_cfg, 8'h28);
		idle();
		for (int k = 0; k < 2; k++) begin
			v = k ? 8'($urandom()) : {5'h01, 3'($urandom())};
			par(1'b0, k[0], {v[7:4], 4'h5}, rd);
			par(1'b0, k[0], {v[3:0], 4'ha}, rd);
			if (k == 0) exp_cfg = apply(exp_cfg, v);
			idle();
		end
		chk("cfg 4-bit", 32'(cfg), 32'(exp_cfg));
		par(1'b1, 1'b0, 8'hff, rd);
		chk("status high", 32'(rd), 32'(exp_cfg.addr_increment ? 8'h00 : 8'h70));
		par(1'b1, 1'b0, 8'hff, rd);
		chk("status low", 32'(rd), 32'(exp_cfg.addr_increment ? 8'h10 : 8'hf0));
		low_voltage_strap = 1'b1;
		ext_reset_n = 1'b0;
		repeat (5) @(negedge clk);
		ext_reset_n = 1'b1;
		wait_idle(n);
		chk("long init", 32'(n >= POR_LO), 32'h1);
		chk("pin reset cfg", 32'(cfg), 32'(CFG_RESET));
		interface_select = 1'b0;
		repeat (4) @(negedge clk);
		pm.start(1'b0, 1'b0);
		repeat (3) pm.bit_xfer(1'b1, d);
		pm.stop();
		exp_cfg = CFG_RESET;
		pm.start(1'b0, 1'b0);
		for (int i = 0; i < 3; i++) begin
			v = i[0] ? {6'h01, 2'($urandom())} : {5'h01, 3'($urandom())};
			pm.word(v, rd);
			exp_cfg = apply(exp_cfg, v);
			idle();
		end
		pm.stop();
		chk("serial cfg", 32'(cfg), 32'(exp_cfg));
		v = 8'($urandom());
		pm.start(1'b0, 1'b1);
		pm.word(v, rd);
		idle();
		pm.start(1'b1, 1'b0);
		pm.start(1'b1, 1'b0);
		pm.word(8'h00, rd);
		chk("serial status", 32'(rd), 32'(exp_cfg.addr_increment ? 8'h01 : 8'h7f));
		pm.start(1'b1, 1'b1);
		pm.start(1'b1, 1'b1);
		pm.word(8'h00, rd);
		chk("filled memory", 32'(rd), 32'(exp_cfg.addr_increment ? SPACE_CODE : 8'h00));
		pm.start(1'b0, 1'b0);
		pm.word(8'h80, rd);
		idle();
		pm.start(1'b1, 1'b1);
		pm.start(1'b1, 1'b1);
		pm.word(8'h00, rd);
		chk("serial data", 32'(rd), 32'(v));
		pm.stop();
		repeat (4) @(negedge clk);
		summarize();
	end
endmodule : tb
